// *** smeme_regs.vh ***
// Register map, field positions, reset values and timing counts for the mode-entry block.
// Assumes inclusion by smeme_unit.v and smeme_core.v; definitions only.
`ifndef SMEME_REGS_VH
`define SMEME_REGS_VH

// Byte addresses on the APB, low 32 address bits
`define SMEME_GMS_ADDR 32'hC3FD_C000
`define SMEME_MRC_ADDR 32'hC3FD_C004
`define SMEME_RCF_ADDR 32'hC3FE_4000
`define SMEME_FLT_ADDR 32'hC3FD_C010
`define SMEME_IST_ADDR 32'hC3FD_C014
`define SMEME_IMK_ADDR 32'hC3FD_C018

// Mode codes and mode request fields
`define SMEME_MODE_SAFE 4'h2
`define SMEME_MODE_DEFAULT_RUN_STATE 4'h3
`define SMEME_MODE_MSB 31
`define SMEME_MODE_LSB 28
`define SMEME_KEY1 16'h5AF0
`define SMEME_KEY2 16'hA50F

// Status register fields
`define SMEME_GMS_TRANS_BIT 27
`define SMEME_GMS_FAIL_BIT 26

// Functional flags that come from the fault collector (upper half-word mask)
`define SMEME_FC_FLAG_MASK 16'h00FF

// Reset values
`define SMEME_RCF_RESET 32'h0000_0000
`define SMEME_IMK_RESET 3'h0

// Interrupt status bits
`define SMEME_IRQ_DONE 0
`define SMEME_IRQ_FAIL 1
`define SMEME_IRQ_RST 2

// Transition timing: time in ns at 40 MHz (25 ns)
`define SMEME_TRANS_NS 200
`define SMEME_CLK_NS 25
`define SMEME_TRANS_CYC ((`SMEME_TRANS_NS + `SMEME_CLK_NS - 1) / `SMEME_CLK_NS)

`endif

// *** smeme_core.v ***
// Mode sequencer: accepts a keyed mode request and walks the transition.
// Assumes a request pulse from the register decoder and a fault summary level.
`timescale 1ns/1ps
`include "smeme_regs.vh"

module smeme_core (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Request
    input wire req_pulse,
    input wire [3:0] req_mode,
    input wire fault_block,
    // Status
    output reg [3:0] cur_mode_q,
    output wire trans_busy,
    output reg done_pulse_q,
    output reg fail_pulse_q
);

    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam [7:0] WAIT_CYC = `SMEME_TRANS_CYC;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] cnt_q;
    reg [3:0] tgt_q;

    assign trans_busy = (state_q == ST_WAIT);

    // Next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (req_pulse) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_q == 8'd1) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Fault check at end of wait decides the outcome, so a fault raised mid-way still blocks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'd0;
            tgt_q <= 4'h0;
            cur_mode_q <= `SMEME_MODE_SAFE;
            done_pulse_q <= 1'b0;
            fail_pulse_q <= 1'b0;
        end else begin
            state_q <= state_d;
            done_pulse_q <= 1'b0;
            fail_pulse_q <= 1'b0;
            if (state_q == ST_IDLE && req_pulse) begin
                cnt_q <= WAIT_CYC;
                tgt_q <= req_mode;
            end else if (state_q == ST_WAIT) begin
                cnt_q <= cnt_q - 8'd1;
                if (cnt_q == 8'd1) begin
                    if (cur_mode_q == `SMEME_MODE_SAFE && fault_block) begin
                        fail_pulse_q <= 1'b1; // Stay in safe
                    end else begin
                        cur_mode_q <= tgt_q;
                        done_pulse_q <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// *** smeme_unit.v ***
// Mode-entry and safe-mode exit block with APB register slave.
// Assumes a single 40 MHz APB clock and fault-collector status as plain levels.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "smeme_regs.vh"

module smeme_unit (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Reset cause events, one-cycle set pulses
    input wire [15:0] func_reset_set,
    input wire [15:0] dest_reset_set,
    // Fault collector
    input wire fault_pending,
    // Status out
    output wire safe_mode,
    output wire irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    reg [15:0] key_q;
    reg key_armed_q;
    reg [31:0] rcf_q;
    reg [31:0] mrc_q;
    reg [2:0] ist_q;
    reg [2:0] imk_q;

    wire acc = psel && penable;
    wire wr = acc && pwrite;

    // Address match helper, used by every register
    function hit;
        input [31:0] a;
        input [31:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    wire is_gms = hit(paddr, `SMEME_GMS_ADDR);
    wire is_mrc = hit(paddr, `SMEME_MRC_ADDR);
    wire is_rcf = hit(paddr, `SMEME_RCF_ADDR);
    wire is_ist = hit(paddr, `SMEME_IST_ADDR);
    wire is_imk = hit(paddr, `SMEME_IMK_ADDR);
    wire mapped = is_gms | is_mrc | is_rcf | is_ist | is_imk;

    // Zero wait states; any unmapped access, or a write to the read-only status, answers with an error
    assign pready = 1'b1;
    assign pslverr = acc && (!mapped || (pwrite && is_gms));

    ////////////////////////////////////////////////////////////////////////////////
    // Mode sequencer

    wire [3:0] cur_mode;
    wire busy;
    wire done_p;
    wire fail_p;

    // Collector flags in the functional half block the exit as well as live faults
    wire fc_flags = |(rcf_q[31:16] & `SMEME_FC_FLAG_MASK);
    wire fault_block = fault_pending | fc_flags;
    assign safe_mode = (cur_mode == `SMEME_MODE_SAFE);

    wire [3:0] w_mode = pwdata[`SMEME_MODE_MSB:`SMEME_MODE_LSB];
    wire w_legal = (w_mode == `SMEME_MODE_SAFE) || (w_mode == `SMEME_MODE_DEFAULT_RUN_STATE);
    // Second write must carry same mode and inverted key
    wire key2_ok = key_armed_q && (pwdata[15:0] == ~key_q)
                   && (w_mode == mrc_q[`SMEME_MODE_MSB:`SMEME_MODE_LSB]);
    wire mrc_wr = wr && is_mrc && !busy;
    wire req_go = mrc_wr && key2_ok && w_legal;

    smeme_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .req_pulse(req_go),
        .req_mode(w_mode),
        .fault_block(fault_block),
        .cur_mode_q(cur_mode),
        .trans_busy(busy),
        .done_pulse_q(done_p),
        .fail_pulse_q(fail_p)
    );

    // Key sequence: first key arms, anything else disarms. Writes during a transition
    // are dropped so a late pair cannot retarget a move already under way.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_q <= 16'h0000;
            key_armed_q <= 1'b0;
            mrc_q <= 32'h0000_0000;
        end else if (mrc_wr) begin
            mrc_q <= pwdata;
            if (key2_ok) begin
                key_armed_q <= 1'b0;
            end else if (pwdata[15:0] == `SMEME_KEY1) begin
                key_armed_q <= 1'b1;
                key_q <= pwdata[15:0];
            end else begin
                key_armed_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset cause flags

    // Set wins over a write-one clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcf_q <= `SMEME_RCF_RESET;
        end else begin
            rcf_q <= (rcf_q & ~((wr && is_rcf) ? pwdata : 32'h0000_0000))
                     | {func_reset_set, dest_reset_set};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts

    wire [2:0] ev = {(|func_reset_set) | (|dest_reset_set), fail_p, done_p};
    wire [2:0] ist_clr = (wr && is_ist) ? pwdata[2:0] : 3'h0;

    // Sticky status, set beats clear; mask writes are ignored in safe mode while fault_block is set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= 3'h0;
            imk_q <= `SMEME_IMK_RESET;
        end else begin
            ist_q <= (ist_q & ~ist_clr) | ev;
            if (wr && is_imk && !(safe_mode && fault_block)) begin
                imk_q <= pwdata[2:0]; // Config locked in faulted safe mode
            end
        end
    end

    assign irq = |(ist_q & imk_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    // Registered read data, loaded in the setup cycle so it is valid in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (is_gms) begin
                prdata[`SMEME_MODE_MSB:`SMEME_MODE_LSB] <= cur_mode;
                prdata[`SMEME_GMS_TRANS_BIT] <= busy;
                prdata[`SMEME_GMS_FAIL_BIT] <= ist_q[`SMEME_IRQ_FAIL];
            end else if (is_mrc) begin
                prdata <= mrc_q;
            end else if (is_rcf) begin
                prdata <= rcf_q;
            end else if (is_ist) begin
                prdata[2:0] <= ist_q;
            end else if (is_imk) begin
                prdata[2:0] <= imk_q;
            end
        end
    end

endmodule

// *** smeme_properties.sv ***
// Concurrent checks on the mode-entry block, seen from its top ports only.
// Assumes smeme_unit ports and a single pclk domain with active-low reset.
`timescale 1ns/1ps
`include "smeme_regs.vh"
module smeme_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // Fault and status
    input wire fault_pending,
    input wire safe_mode,
    input wire irq
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire acc = psel && penable;
wire wr = acc && pwrite;
wire to_mrc = wr && paddr == `SMEME_MRC_ADDR;
reg [3:0] k2_cnt_q;
////////////////////////////////////////////////////////////////////////
// Cycles since the last second-key write; saturates so old writes age out
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        k2_cnt_q <= 4'hF;
    else if (to_mrc && pwdata == 32'h3000_A50F)
        k2_cnt_q <= 4'h0;
    else if (k2_cnt_q != 4'hF)
        k2_cnt_q <= k2_cnt_q + 4'h1;
end
sequence s_key1;
    safe_mode && to_mrc && pwdata == 32'h3000_5AF0;
endsequence
sequence s_quiet;
    (!wr) [*8];
endsequence
////////////////////////////////////////////////////////////////////////
property p_lone_key;
    s_key1 ##1 s_quiet |-> safe_mode;
endproperty
a_lone_key: assert property (p_lone_key) else $error("lone first key left safe mode");
property p_exit_time;
    $fell(safe_mode) |-> k2_cnt_q >= 4'h6 && k2_cnt_q <= 4'hA;
endproperty
a_exit_time: assert property (p_exit_time) else $error("safe mode left off schedule");
property p_fault_hold;
    safe_mode && fault_pending |=> safe_mode || !fault_pending;
endproperty
a_fault_hold: assert property (p_fault_hold) else $error("exit despite pending fault");
property p_status_ro;
    wr && paddr == `SMEME_GMS_ADDR |-> pslverr;
endproperty
a_status_ro: assert property (p_status_ro) else $error("status write not refused");
property p_unmapped;
    acc && paddr == `SMEME_FLT_ADDR |-> pslverr;
endproperty
a_unmapped: assert property (p_unmapped) else $error("hole not refused");
property p_status_read;
    acc && !pwrite && paddr == `SMEME_GMS_ADDR |-> pready && !pslverr;
endproperty
a_status_read: assert property (p_status_read) else $error("status read refused");
property p_irq_sticky;
    $fell(irq) |-> $past(wr);
endproperty
a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped without a write");
property p_reset_safe;
    $rose(presetn) |-> safe_mode;
endproperty
a_reset_safe: assert property (p_reset_safe) else $error("not in safe mode at reset");
endmodule
bind smeme_unit smeme_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .fault_pending(fault_pending), .safe_mode(safe_mode), .irq(irq));

// *** safe_mode_exit_mode_entry_bench.sv ***
// Self-checking bench for the mode-entry block, driven over APB.
// Assumes smeme_unit with the checker bound to it.
`timescale 1ns/1ps
`include "smeme_regs.vh"
module safe_mode_exit_mode_entry_bench;
reg pclk = 1'b0;
reg presetn = 1'b0;
reg psel = 1'b0;
reg penable = 1'b0;
reg pwrite = 1'b0;
reg [31:0] paddr = 32'h0;
reg [31:0] pwdata = 32'h0;
reg [15:0] func_reset_set = 16'h0;
reg [15:0] dest_reset_set = 16'h0;
reg fault_pending = 1'b0;
wire pready, pslverr, safe_mode, irq;
wire [31:0] prdata;
reg [31:0] rdat;
reg rerr;
integer n_mismatch = 0;
integer num_checks = 0;
smeme_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .func_reset_set(func_reset_set), .dest_reset_set(dest_reset_set),
    .fault_pending(fault_pending), .safe_mode(safe_mode), .irq(irq));
// 40 MHz clock
always #12.5 pclk = ~pclk;
////////////////////////////////////////////////////////////////////////
task chk(input [31:0] got, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
// One transfer; the watchdog cuts a pready that never comes
task apb(input w, input [31:0] a, input [31:0] d);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
task rdchk(input [31:0] a, input [31:0] m, input [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    end
endtask
task req(input [31:0] k2);
    begin
        apb(1'b1, `SMEME_MRC_ADDR, 32'h3000_5AF0);
        apb(1'b1, `SMEME_MRC_ADDR, k2);
    end
endtask
// Poll the pending bit under a bounded count, then read mode and fail bit
task wait_done(input [31:0] e);
    integer i;
    begin
        // Read the pending bit fresh; rdat may still hold an older transfer
        apb(1'b0, `SMEME_GMS_ADDR, 32'h0);
        for (i = 0; i < 40 && rdat[27] !== 1'b0; i = i + 1) apb(1'b0, `SMEME_GMS_ADDR, 32'h0);
        rdchk(`SMEME_GMS_ADDR, 32'hFC00_0000, e);
    end
endtask
////////////////////////////////////////////////////////////////////////
task t_reset_state;
    begin
        rdchk(`SMEME_GMS_ADDR, 32'hF800_0000, 32'h2000_0000);
        chk(safe_mode, 1'b1);
        rdchk(`SMEME_RCF_ADDR, 32'hFFFF_FFFF, 32'h0);
        apb(1'b1, `SMEME_GMS_ADDR, 32'h3000_0000);
        chk(rerr, 1'b1);
        apb(1'b0, `SMEME_FLT_ADDR, 32'h0);
        chk(rerr, 1'b1);
    end
endtask
task t_bad_keys;
    begin
        apb(1'b1, `SMEME_MRC_ADDR, 32'h3000_5AF0);
        repeat (10) @(posedge pclk);
        rdchk(`SMEME_GMS_ADDR, 32'hF800_0000, 32'h2000_0000);
        req(32'h3000_1234);
        rdchk(`SMEME_GMS_ADDR, 32'hF800_0000, 32'h2000_0000);
    end
endtask
// A collector flag left set must block the exit; clearing is write-one
task t_flag_block;
    begin
        @(posedge pclk);
        func_reset_set <= 16'h0001;
        dest_reset_set <= 16'h0008;
        @(posedge pclk);
        func_reset_set <= 16'h0;
        dest_reset_set <= 16'h0;
        rdchk(`SMEME_RCF_ADDR, 32'hFFFF_FFFF, 32'h0001_0008);
        apb(1'b1, `SMEME_RCF_ADDR, 32'h0000_0008);
        rdchk(`SMEME_RCF_ADDR, 32'hFFFF_FFFF, 32'h0001_0000);
        req(32'h3000_A50F);
        wait_done(32'h2400_0000);
        apb(1'b1, `SMEME_RCF_ADDR, 32'hFFFF_FFFF);
        rdchk(`SMEME_RCF_ADDR, 32'hFFFF_FFFF, 32'h0);
    end
endtask
task t_fault_block;
    begin
        fault_pending <= 1'b1;
        apb(1'b1, `SMEME_IMK_ADDR, 32'h1);
        rdchk(`SMEME_IMK_ADDR, 32'h7, 32'h0);
        req(32'h3000_A50F);
        wait_done(32'h2400_0000);
        fault_pending <= 1'b0;
    end
endtask
// Sticky causes stay hidden until unmasked, then clear by writing ones
task t_irq;
    begin
        @(negedge pclk) chk(irq, 1'b0);
        apb(1'b1, `SMEME_IMK_ADDR, 32'h6);
        @(negedge pclk) chk(irq, 1'b1);
        apb(1'b1, `SMEME_IST_ADDR, 32'h7);
        @(negedge pclk) chk(irq, 1'b0);
    end
endtask
task t_exit;
    begin
        req(32'h3000_A50F);
        rdchk(`SMEME_GMS_ADDR, 32'h0800_0000, 32'h0800_0000);
        wait_done(32'h3000_0000);
        @(negedge pclk) chk(safe_mode, 1'b0);
    end
endtask
////////////////////////////////////////////////////////////////////////
task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
endtask
// Main sequence after an 8-cycle reset
initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_state;
    t_bad_keys;
    t_flag_block;
    t_fault_block;
    t_irq;
    t_exit;
    tally_and_finish;
end
// Watchdog, far beyond the few hundred cycles the tests need
initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
end
endmodule
